// [rtl/cfg_readback_host.v]
// Host controller running the configuration-memory readback sequence
//
// How it works
// - Sync word opens every sequence
// - Command write: header then command code
// - Shutdown mode: halt, then CRC reset
// - Four no-op words after CRC reset
// - Write start frame address, one word
// - Then write read-configuration command
// - Type 1 zero-count read, then Type 2
// - Length is words per frame times frames+1
// - Two no-op pads before reading
// - Read exactly requested words; first frame pad
// - Then startup, CRC reset, desync commands
// - End with 64 no-op bits, clock until done
// - One packet per step, except sync, read
// - Active mode drops halt, wait, startup
// - Active mode avoids memory-holding frames
// - Frame address auto-increments per frame read
// - Switch port to read, then back to write
// - Port must persist, readback unsecured
`include "cfg_readback_consts.vh"

module cfg_readback_host (
	// System clock and reset
	input wire i_sys_clk,
	input wire i_srst,
	// AXI4-Lite write address
	input wire i_awvalid,
	output wire o_awready,
	input wire [7:0] i_awaddr,
	input wire [2:0] i_awprot,
	// AXI4-Lite write data
	input wire i_wvalid,
	output wire o_wready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	// AXI4-Lite write response
	output wire o_bvalid,
	input wire i_bready,
	output wire [1:0] o_bresp,
	// AXI4-Lite read address
	input wire i_arvalid,
	output wire o_arready,
	input wire [7:0] i_araddr,
	input wire [2:0] i_arprot,
	// AXI4-Lite read data
	output wire o_rvalid,
	input wire i_rready,
	output wire [31:0] o_rdata,
	output wire [1:0] o_rresp,
	// Configuration port pins
	output wire o_config_clock,
	output wire o_cs_n,
	output wire o_rdwr_n,
	output wire [31:0] o_cfg_data,
	output wire o_cfg_data_oe,
	input wire [31:0] i_cfg_data,
	input wire i_done
);

	// Sequencer states
	localparam ST_IDLE = 3'h0;
	localparam ST_SEND = 3'h1;
	localparam ST_TURN_RD = 3'h2;
	localparam ST_READ = 3'h3;
	localparam ST_TURN_WR = 3'h4;
	localparam ST_WAIT_DONE = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	reg [2:0] state_r; // Sequencer state
	reg [4:0] idx_r; // Position in the word sequence
	reg active_r; // Readback while design runs
	reg [31:0] frame_addr_r; // Starting frame address
	reg [`TYPE2_CNT_W-1:0] len_r; // Words to read
	reg [`TYPE2_CNT_W-1:0] cnt_r; // Words read so far
	reg [31:0] data_r; // Last word read back
	reg data_valid_r; // Word waiting for software
	reg done_low_seen_r; // Done seen low during this run
	reg done_s1_r; // Done synchroniser stages
	reg done_s2_r;
	reg done_s3_r;
	reg done_r; // Filtered done level
	reg cs_n_r; // Pin registers
	reg rdwr_n_r;
	reg oe_r;
	reg [31:0] dout_r;
	reg cs_n_nxt; // Pin next values
	reg rdwr_n_nxt;
	reg oe_nxt;
	reg [31:0] dout_nxt;
	reg aw_full_r; // Write address held
	reg [7:0] aw_addr_r;
	reg w_full_r; // Write data held
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg bvalid_r; // Write response pending
	reg [1:0] bresp_r;
	reg rvalid_r; // Read response pending
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;
	wire cfg_clk; // Generated configuration clock
	wire rise; // Edge strobes of that clock
	wire fall;
	wire run; // Clock may advance
	wire do_write; // Register write happens now
	wire do_read; // Register read taken now
	wire go; // Start request accepted
	wire last_word; // Final read word being taken

	////////////////////////////////////////////////////////////////////////
	// Sequence helpers

	// Word sent at each sequence position
	function [31:0] seq_word;
		input [4:0] idx;
		input [31:0] faddr;
		input [`TYPE2_CNT_W-1:0] len;
		begin
			case (idx)
				5'h00: seq_word = `W_SYNC;
				5'h01: seq_word = `W_HDR_CMD;
				5'h02: seq_word = `CMD_SHUTDOWN;
				5'h03: seq_word = `W_HDR_CMD;
				5'h04: seq_word = `CMD_CRC_RESET;
				5'h09: seq_word = `W_HDR_FRAME_ADDR;
				5'h0A: seq_word = faddr;
				5'h0B: seq_word = `W_HDR_CMD;
				5'h0C: seq_word = `CMD_READ_CONFIG;
				5'h0D: seq_word = `W_HDR_FRAME_OUT;
				5'h0E: seq_word = `W_TYPE2_READ | {5'h00, len};
				5'h11: seq_word = `W_HDR_CMD;
				5'h12: seq_word = `CMD_STARTUP;
				5'h13: seq_word = `W_HDR_CMD;
				5'h14: seq_word = `CMD_CRC_RESET;
				5'h15: seq_word = `W_HDR_CMD;
				5'h16: seq_word = `CMD_DESYNC;
				// Waits, read pads and final flush
				default: seq_word = `W_NO_OPERATION;
			endcase
		end
	endfunction

	// Next position; active mode skips the halt and its wait
	function [4:0] seq_next;
		input [4:0] idx;
		input active;
		begin
			if (active && idx == `SEQ_HALT_SKIP_FROM)
				seq_next = `SEQ_HALT_SKIP_TO;
			else if (active && idx == `SEQ_WAIT_SKIP_FROM)
				seq_next = `SEQ_WAIT_SKIP_TO;
			else
				seq_next = idx + 5'h01;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Clock generation; stalls in ST_READ while a read word waits for software
	assign run = (state_r != ST_IDLE) && !(state_r == ST_READ && data_valid_r);

	cfg_clk_gen u_clk (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_run(run),
		.o_cfg_clk(cfg_clk),
		.o_rise(rise),
		.o_fall(fall)
	);

	////////////////////////////////////////////////////////////////////////
	// Done input: three stages, accept when last two agree
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			done_s1_r <= 1'b0;
			done_s2_r <= 1'b0;
			done_s3_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_s1_r <= i_done;
			done_s2_r <= done_s1_r;
			done_s3_r <= done_s2_r;
			if (done_s2_r == done_s3_r) begin
				done_r <= done_s3_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: advances on each rising config clock edge
	assign go = do_write && (aw_addr_r == `A_CTRL) && w_strb_r[0] &&
		w_data_r[`CTRL_GO] && (state_r == ST_IDLE);
	assign last_word = (cnt_r + 27'h000_0001 == len_r);

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_r <= ST_IDLE;
			idx_r <= `SEQ_FIRST;
			cnt_r <= `RST_LEN;
			data_r <= `RST_WORD;
			data_valid_r <= 1'b0;
			done_low_seen_r <= 1'b0;
		end else begin
			// Done low confirms the shutdown took effect
			if (state_r != ST_IDLE && !done_r) begin
				done_low_seen_r <= 1'b1;
			end
			// Software read of the data word frees it
			if (do_read && i_araddr == `A_DATA) begin
				data_valid_r <= 1'b0;
			end
			case (state_r)
				ST_IDLE: begin
					if (go) begin
						state_r <= ST_SEND;
						idx_r <= `SEQ_FIRST;
						cnt_r <= `RST_LEN;
						done_low_seen_r <= 1'b0;
					end
				end
				ST_SEND: begin
					// One word taken per rising edge
					if (rise) begin
						if (idx_r == `SEQ_READ_AT) begin
							state_r <= ST_TURN_RD;
						end else if (idx_r == `SEQ_LAST) begin
							state_r <= ST_WAIT_DONE;
						end else begin
							idx_r <= seq_next(idx_r, active_r);
						end
					end
				end
				ST_TURN_RD: begin
					// Deselected edge while the bus turns round
					if (rise) begin
						state_r <= (len_r == `RST_LEN) ? ST_TURN_WR : ST_READ;
					end
				end
				ST_READ: begin
					// Take exactly the requested words, pad frame included
					if (rise) begin
						data_r <= i_cfg_data;
						data_valid_r <= 1'b1;
						cnt_r <= cnt_r + 27'h000_0001;
						if (last_word) begin
							state_r <= ST_TURN_WR;
						end
					end
				end
				ST_TURN_WR: begin
					// Back to write control; active mode skips startup
					if (rise) begin
						state_r <= ST_SEND;
						idx_r <= active_r ? `SEQ_POST_ACTIVE : `SEQ_POST;
					end
				end
				ST_WAIT_DONE: begin
					// Keep clocking until the device reports done
					if (rise && done_r) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin values for the current state
	always @* begin
		cs_n_nxt = 1'b1;
		rdwr_n_nxt = 1'b0;
		oe_nxt = 1'b0;
		dout_nxt = `RST_WORD;
		case (state_r)
			ST_SEND: begin
				cs_n_nxt = 1'b0;
				oe_nxt = 1'b1;
				dout_nxt = seq_word(idx_r, frame_addr_r, len_r);
			end
			ST_TURN_RD: begin
				rdwr_n_nxt = 1'b1;
			end
			ST_READ: begin
				cs_n_nxt = 1'b0;
				rdwr_n_nxt = 1'b1;
			end
			default: begin
				cs_n_nxt = 1'b1;
			end
		endcase
	end

	// Pins change only while the config clock is low
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			cs_n_r <= 1'b1;
			rdwr_n_r <= 1'b0;
			oe_r <= 1'b0;
			dout_r <= `RST_WORD;
		end else if (!cfg_clk || fall) begin
			cs_n_r <= cs_n_nxt;
			rdwr_n_r <= rdwr_n_nxt;
			oe_r <= oe_nxt;
			dout_r <= dout_nxt;
		end
	end

	assign o_config_clock = cfg_clk;
	assign o_cs_n = cs_n_r;
	assign o_rdwr_n = rdwr_n_r;
	assign o_cfg_data = dout_r;
	assign o_cfg_data_oe = oe_r;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data taken in either order
	assign o_awready = !aw_full_r && !bvalid_r;
	assign o_wready = !w_full_r && !bvalid_r;
	assign do_write = aw_full_r && w_full_r && !bvalid_r;
	assign o_bvalid = bvalid_r;
	assign o_bresp = bresp_r;

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_full_r <= 1'b0;
			w_data_r <= `RST_WORD;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			active_r <= 1'b0;
			frame_addr_r <= `RST_WORD;
			len_r <= `RST_LEN;
		end else begin
			// Hold each half until both are present
			if (i_awvalid && o_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= i_wdata;
				w_strb_r <= i_wstrb;
			end
			if (do_write) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= `RESP_OKAY;
				case (aw_addr_r)
					`A_CTRL: begin
						// Mode is frozen while a sequence runs
						if (w_strb_r[0] && state_r == ST_IDLE) begin
							active_r <= w_data_r[`CTRL_ACTIVE];
						end
					end
					`A_FRAME_ADDR: begin
						if (state_r == ST_IDLE) begin
							frame_addr_r <= w_data_r;
						end
					end
					`A_READ_LEN: begin
						if (state_r == ST_IDLE) begin
							len_r <= w_data_r[`TYPE2_CNT_W-1:0];
						end
					end
					`A_STATUS, `A_DATA, `A_COUNT: begin
						bresp_r <= `RESP_OKAY;
					end
					default: begin
						bresp_r <= `RESP_SLVERR;
					end
				endcase
			end else if (bvalid_r && i_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path: one cycle after the address is taken
	assign o_arready = !rvalid_r;
	assign do_read = i_arvalid && o_arready;
	assign o_rvalid = rvalid_r;
	assign o_rdata = rdata_r;
	assign o_rresp = rresp_r;

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			rvalid_r <= 1'b0;
			rdata_r <= `RST_WORD;
			rresp_r <= `RESP_OKAY;
		end else if (do_read) begin
			rvalid_r <= 1'b1;
			rresp_r <= `RESP_OKAY;
			rdata_r <= `RST_WORD;
			case (i_araddr)
				`A_CTRL: rdata_r[`CTRL_ACTIVE] <= active_r;
				`A_FRAME_ADDR: rdata_r <= frame_addr_r;
				`A_READ_LEN: rdata_r <= {5'h00, len_r};
				`A_STATUS: begin
					rdata_r[`ST_BUSY] <= (state_r != ST_IDLE);
					rdata_r[`ST_DONE] <= done_r;
					rdata_r[`ST_DATA_VALID] <= data_valid_r;
					rdata_r[`ST_DONE_LOW_SEEN] <= done_low_seen_r;
				end
				`A_DATA: rdata_r <= data_r;
				`A_COUNT: rdata_r <= {5'h00, cnt_r};
				default: rresp_r <= `RESP_SLVERR;
			endcase
		end else if (rvalid_r && i_rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule // cfg_readback_host

// [include/cfg_readback_consts.vh]
// Constants for the configuration-memory readback controller
`ifndef CFG_READBACK_CONSTS_VH
`define CFG_READBACK_CONSTS_VH

// Words sent on the configuration port
`define W_SYNC 32'hAA99_5566
`define W_HDR_CMD 32'h3000_8001
`define W_HDR_FRAME_ADDR 32'h3000_2001
`define W_HDR_FRAME_OUT 32'h2800_6000
`define W_TYPE2_READ 32'h4800_0000
`define W_NO_OPERATION 32'h2000_0000
`define CMD_SHUTDOWN 32'h0000_000B
`define CMD_CRC_RESET 32'h0000_0007
`define CMD_READ_CONFIG 32'h0000_0004
`define CMD_STARTUP 32'h0000_0005
`define CMD_DESYNC 32'h0000_000D

// Type 2 word-count field width
`define TYPE2_CNT_W 27

// Sequence positions
`define SEQ_FIRST 5'h00
`define SEQ_HALT_SKIP_FROM 5'h00
`define SEQ_HALT_SKIP_TO 5'h03
`define SEQ_WAIT_SKIP_FROM 5'h04
`define SEQ_WAIT_SKIP_TO 5'h09
`define SEQ_READ_AT 5'h10
`define SEQ_POST 5'h11
`define SEQ_POST_ACTIVE 5'h13
`define SEQ_LAST 5'h18

// Config clock half period in system clocks (320 ns period at 25 MHz)
`define CFG_HALF 4'h4
`define CFG_HALF_W 4

// Register offsets (byte addresses)
`define A_CTRL 8'h00
`define A_FRAME_ADDR 8'h04
`define A_READ_LEN 8'h08
`define A_STATUS 8'h0C
`define A_DATA 8'h10
`define A_COUNT 8'h14

// Control and status bits
`define CTRL_GO 0
`define CTRL_ACTIVE 1
`define ST_BUSY 0
`define ST_DONE 1
`define ST_DATA_VALID 2
`define ST_DONE_LOW_SEEN 3

// Reset values and bus answers
`define RST_WORD 32'h0000_0000
`define RST_LEN 27'h000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/cfg_clk_gen.v]
// Configuration clock divider with edge strobes for the controller
`include "cfg_readback_consts.vh"

module cfg_clk_gen (
	// System clock and reset
	input wire i_sys_clk,
	input wire i_srst,
	// Run request; clock parks low when dropped
	input wire i_run,
	// Generated clock and edge strobes
	output wire o_cfg_clk,
	output wire o_rise,
	output wire o_fall
);

	reg [`CFG_HALF_W-1:0] cnt_r; // Cycles spent in current phase
	reg clk_r; // Clock level driven out
	wire half_done; // Phase has lasted its full half period

	assign half_done = (cnt_r == `CFG_HALF - 4'h1);
	// Rise only on request; fall always completes a high phase
	assign o_rise = half_done && !clk_r && i_run;
	assign o_fall = half_done && clk_r;
	assign o_cfg_clk = clk_r;

	////////////////////////////////////////////////////////////////////////
	// Phase counter and clock level
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			cnt_r <= {`CFG_HALF_W{1'b0}};
			clk_r <= 1'b0;
		end else if (o_rise || o_fall) begin
			// Edge taken, new phase starts
			cnt_r <= {`CFG_HALF_W{1'b0}};
			clk_r <= !clk_r;
		end else if (!clk_r && !i_run) begin
			// Parked low, full low phase before next rise
			cnt_r <= {`CFG_HALF_W{1'b0}};
		end else if (!half_done) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

endmodule // cfg_clk_gen

// [sim/cfg_readback_host_sva.sv]
// Checker for the readback host: link pin timing and bus answers
`include "cfg_readback_consts.vh"

module cfg_readback_host_sva (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// Bus handshakes
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic [1:0] o_bresp,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [31:0] o_rdata,
	// Configuration port
	input wire logic o_config_clock,
	input wire logic o_cs_n,
	input wire logic o_rdwr_n,
	input wire logic [31:0] o_cfg_data,
	input wire logic o_cfg_data_oe,
	input wire logic i_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);

	////////////////////////////////////////////////////////////////////////////////
	// Link clock shape and pin stability
	chk_clk_high_len: assert property ($rose(o_config_clock) |-> o_config_clock[*4] ##1 !o_config_clock)
		else $error("config clock high phase not four cycles");
	chk_clk_low_min: assert property ($fell(o_config_clock) |-> !o_config_clock[*4])
		else $error("config clock low phase too short");
	chk_pins_hold: assert property (o_config_clock |-> $stable(o_cfg_data) && $stable(o_cs_n)
		&& $stable(o_rdwr_n) && $stable(o_cfg_data_oe))
		else $error("port pins moved while config clock high");
	chk_oe_write_only: assert property (o_cfg_data_oe |-> !o_rdwr_n)
		else $error("data driven under read control");
	chk_dir_deselect: assert property ($changed(o_rdwr_n) |-> o_cs_n)
		else $error("direction changed while selected");

	////////////////////////////////////////////////////////////////////////////////
	// Register bus answers
	chk_b_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
		|-> ##2 o_bvalid)
		else $error("write response late");
	chk_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped early");
	chk_r_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read data late");
	chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped early");
	chk_ar_block: assert property (o_rvalid |-> !o_arready)
		else $error("read address taken while data pending");

	// Main scenarios reached
	cov_done_low: cover property ($fell(i_done));
	cov_read_edge: cover property ($rose(o_config_clock) && !o_cs_n && o_rdwr_n);
	cov_slverr: cover property (o_bvalid && o_bresp == `RESP_SLVERR);
endmodule // cfg_readback_host_sva

bind cfg_readback_host cfg_readback_host_sva u_cfg_readback_host_sva (
	.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_awvalid(i_awvalid), .o_awready(o_awready),
	.i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
	.o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
	.i_rready(i_rready), .o_rdata(o_rdata), .o_config_clock(o_config_clock), .o_cs_n(o_cs_n),
	.o_rdwr_n(o_rdwr_n), .o_cfg_data(o_cfg_data), .o_cfg_data_oe(o_cfg_data_oe), .i_done(i_done));

// [sim/cfg_device_model.sv]
// Behavioural configuration device answering the readback host
`include "cfg_readback_consts.vh"

module cfg_device_model #(
	parameter int DONE_DLY = 10
) (
	// Port pins from the host
	input wire logic i_config_clock,
	input wire logic i_cs_n,
	input wire logic i_rdwr_n,
	input wire logic [31:0] i_wdata,
	// Answers to the host
	output logic [31:0] o_rdata,
	output logic o_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rx_q[$]; // Words taken from the host
	logic [31:0] prev_w; // Previous word, to spot command codes
	int rd_cnt; // Words returned this run
	int halt_cnt; // Edges until shutdown completes
	int run_cnt; // Edges until startup completes
	wire rd_sel = !i_cs_n && i_rdwr_n;

	// Pattern while read, its inverse once released
	assign o_rdata = rd_sel ? 32'hC0DE_0000 + rd_cnt : ~(32'hC0DE_0000 + rd_cnt);

	initial begin
		o_done = 1'b1;
		prev_w = 32'h0000_0000;
		rd_cnt = 0;
		halt_cnt = 0;
		run_cnt = 0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Words are taken on the config clock rising edge
	always @(posedge i_config_clock) begin
		if (halt_cnt > 0)
			halt_cnt <= halt_cnt - 1;
		if (halt_cnt == 1)
			o_done <= 1'b0;
		if (run_cnt > 0)
			run_cnt <= run_cnt - 1;
		if (run_cnt == 1)
			o_done <= 1'b1;
		if (rd_sel)
			rd_cnt <= rd_cnt + 1;
		if (!i_cs_n && !i_rdwr_n) begin
			rx_q.push_back(i_wdata);
			prev_w <= i_wdata;
			if (i_wdata == `W_SYNC)
				rd_cnt <= 0;
			if (prev_w == `W_HDR_CMD && i_wdata == `CMD_SHUTDOWN)
				halt_cnt <= 3;
			if (prev_w == `W_HDR_CMD && i_wdata == `CMD_STARTUP)
				run_cnt <= DONE_DLY;
		end
	end
endmodule // cfg_device_model

// [sim/tb_cfg_readback_host.sv]
// Self-checking bench for the readback host controller
`include "cfg_readback_consts.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	$display("[ERR] %s exp %h got %h", nm, ex, got); fail_count++; end end

module tb_cfg_readback_host;
	timeunit 1ns;
	timeprecision 1ps;
	// Clock, reset, counters
	logic i_sys_clk, i_srst;
	int fail_count, cmp_count;
	// Bus signals
	logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata;
	logic [3:0] i_wstrb;
	logic [2:0] i_awprot, i_arprot;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	// Configuration port
	logic o_config_clock, o_cs_n, o_rdwr_n, o_cfg_data_oe, i_done;
	logic [31:0] o_cfg_data, i_cfg_data;
	logic [31:0] exp_q[$]; // Expected link words

	cfg_readback_host u_cfg_readback_host (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_awprot(i_awprot),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
		.o_arready(o_arready), .i_araddr(i_araddr), .i_arprot(i_arprot), .o_rvalid(o_rvalid),
		.i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.o_config_clock(o_config_clock), .o_cs_n(o_cs_n), .o_rdwr_n(o_rdwr_n),
		.o_cfg_data(o_cfg_data), .o_cfg_data_oe(o_cfg_data_oe), .i_cfg_data(i_cfg_data),
		.i_done(i_done));
	cfg_device_model u_cfg_device_model (.i_config_clock(o_config_clock), .i_cs_n(o_cs_n),
		.i_rdwr_n(o_rdwr_n), .i_wdata(o_cfg_data), .o_rdata(i_cfg_data), .o_done(i_done));

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and bounded waits
	task automatic final_report();
		$display("Counts: compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic guard(input bit ok);
		if (!ok) begin
			$display("[ERR] wait bound exp 1 got 0");
			fail_count++;
			final_report();
		end
	endtask

	// Bus write: address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_sys_clk);
			if (i_awvalid && o_awready)
				i_awvalid <= 1'b0;
			if (i_wvalid && o_wready)
				i_wvalid <= 1'b0;
			n++;
		end while (!(i_bready && o_bvalid) && n < 100);
		`CHK("bresp", er, o_bresp)
		i_bready <= 1'b0;
		guard(n < 100);
	endtask

	// Bus read with data and response returned
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_sys_clk);
			if (i_arvalid && o_arready)
				i_arvalid <= 1'b0;
			n++;
		end while (!(i_rready && o_rvalid) && n < 100);
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
		guard(n < 100);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		`CHK(nm, ex, d)
		`CHK("rresp", er, r)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Expected link words for one run
	function automatic void build_exp(input bit act, input logic [31:0] fa, input logic [26:0] len);
		exp_q = {`W_SYNC};
		if (!act)
			exp_q = {exp_q, `W_HDR_CMD, `CMD_SHUTDOWN};
		exp_q = {exp_q, `W_HDR_CMD, `CMD_CRC_RESET};
		if (!act) begin
			exp_q = {exp_q, `W_NO_OPERATION, `W_NO_OPERATION};
			exp_q = {exp_q, `W_NO_OPERATION, `W_NO_OPERATION};
		end
		exp_q = {exp_q, `W_HDR_FRAME_ADDR, fa, `W_HDR_CMD, `CMD_READ_CONFIG};
		exp_q = {exp_q, `W_HDR_FRAME_OUT, `W_TYPE2_READ | {5'h00, len}};
		exp_q = {exp_q, `W_NO_OPERATION, `W_NO_OPERATION};
		if (!act)
			exp_q = {exp_q, `W_HDR_CMD, `CMD_STARTUP};
		exp_q = {exp_q, `W_HDR_CMD, `CMD_CRC_RESET, `W_HDR_CMD, `CMD_DESYNC};
		exp_q = {exp_q, `W_NO_OPERATION, `W_NO_OPERATION};
	endfunction

	// Reset values, read-length width, unmapped address
	task automatic test_regs();
		rd_chk("status idle", `A_STATUS, 32'h0000_0002, `RESP_OKAY);
		rd_chk("count idle", `A_COUNT, `RST_WORD, `RESP_OKAY);
		rd_chk("ctrl idle", `A_CTRL, `RST_WORD, `RESP_OKAY);
		axi_wr(`A_READ_LEN, 32'hFFFF_FFFF, `RESP_OKAY);
		rd_chk("len width", `A_READ_LEN, 32'h07FF_FFFF, `RESP_OKAY);
		axi_wr(8'h18, 32'h1234_5678, `RESP_SLVERR);
		rd_chk("unmapped", 8'h18, 32'h0000_0000, `RESP_SLVERR);
		$display("test_regs finished");
	endtask

	// Full readback run; a busy write must be ignored
	task automatic test_run(input bit act, input logic [31:0] fa, input logic [26:0] len);
		logic [31:0] d, st;
		logic [1:0] r;
		int k, n;
		k = 0;
		n = 0;
		build_exp(act, fa, len);
		u_cfg_device_model.rx_q.delete();
		axi_wr(`A_FRAME_ADDR, fa, `RESP_OKAY);
		axi_wr(`A_READ_LEN, {5'h00, len}, `RESP_OKAY);
		axi_wr(`A_CTRL, {30'h0000_0000, act, 1'b1}, `RESP_OKAY);
		axi_wr(`A_FRAME_ADDR, 32'hFFFF_0000, `RESP_OKAY);
		do begin
			axi_rd(`A_STATUS, st, r);
			if (st[`ST_DATA_VALID]) begin
				axi_rd(`A_DATA, d, r);
				`CHK("read word", 32'hC0DE_0000 + k, d)
				k++;
			end
			n++;
		end while (st[`ST_BUSY] && n < 5000);
		guard(n < 5000);
		`CHK("words", 32'(len), 32'(k))
		`CHK("device reads", 32'(len), 32'(u_cfg_device_model.rd_cnt))
		rd_chk("count", `A_COUNT, {5'h00, len}, `RESP_OKAY);
		rd_chk("frame addr", `A_FRAME_ADDR, fa, `RESP_OKAY);
		rd_chk("status end", `A_STATUS, {28'h000_0000, !act, 3'h2}, `RESP_OKAY);
		`CHK("word total", exp_q.size(), u_cfg_device_model.rx_q.size())
		foreach (exp_q[i])
			`CHK("link word", exp_q[i], u_cfg_device_model.rx_q[i])
		$display("test_run act %0d len %0d finished", act, len);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock and main sequence
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	initial begin
		i_srst = 1'b1;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
		i_awaddr = 8'h00;
		i_araddr = 8'h00;
		i_wdata = 32'h0000_0000;
		i_wstrb = 4'hF;
		i_awprot = 3'h0;
		i_arprot = 3'h0;
		fail_count = 0;
		cmp_count = 0;
		repeat (16) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		// Done filter needs a few cycles to show the pin level
		repeat (4) @(posedge i_sys_clk);
		test_regs();
		test_run(1'b0, 32'h0000_0000, 27'h000_0006);
		test_run(1'b1, 32'h0000_0040, 27'h000_0004);
		test_run(1'b0, 32'h0000_0200, 27'h000_0000);
		final_report();
	end
endmodule // tb_cfg_readback_host
